// ==== digital_comparator_chk.sv ====
// Concurrent checks on the top ports of the compare PWM block.
// Assumes one clock and a master that holds each request until waitrequest is low.
`timescale 1ns/10ps
module digital_comparator_chk
    import digital_comparator_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire logic [7:0]           address,
    input wire logic                 read,
    input wire logic                 write,
    input wire logic [31:0]          readdata,
    input wire logic                 waitrequest,
    input wire logic                 shared_power_down,
    input wire logic [7:0]           ramp_counter,
    input wire logic [NUM_UNITS-1:0] pwm_pos,
    input wire logic [NUM_UNITS-1:0] pwm_neg
);
    // Everything here lives in the single clock domain.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_wait_once;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_once: assert property (p_wait_once) else $error("Request was not answered after one wait state.");

    property p_ack_single;
        (read || write) && !waitrequest |=> waitrequest || !(read || write);
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("Answer stood longer than one cycle.");

    property p_unmapped_zero;
        read && !waitrequest && address == 8'h08 |-> readdata == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read returned nonzero data.");

    property p_ctrl_upper_zero;
        read && !waitrequest && address == 8'h20 |-> readdata[31:7] == 25'h0;
    endproperty
    a_ctrl_upper_zero: assert property (p_ctrl_upper_zero) else $error("Unused control bits read nonzero.");

    // The first two edges after reset are skipped because the ramp may still be reloading.
    property p_ramp_step;
        !$past(sys_rst) && !$past(sys_rst, 2) |-> 8'(ramp_counter - $past(ramp_counter)) inside {8'h01, 8'hff};
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("Ramp did not move by one step.");

    property p_power_down_quiet;
        shared_power_down [*5] |-> pwm_pos == '0 && pwm_neg == '0;
    endproperty
    a_power_down_quiet: assert property (p_power_down_quiet) else $error("Outputs active while powered down.");

    property p_pos_gap;
        (pwm_pos & ~$past(pwm_pos) & $past(pwm_neg)) == '0;
    endproperty
    a_pos_gap: assert property (p_pos_gap) else $error("Positive output rose without a dead band.");

    property p_neg_gap;
        (pwm_neg & ~$past(pwm_neg) & $past(pwm_pos)) == '0;
    endproperty
    a_neg_gap: assert property (p_neg_gap) else $error("Negative output rose without a dead band.");
endmodule : digital_comparator_chk

bind digital_compare_pwm_unit digital_comparator_chk u_digital_comparator_chk (.mclk(mclk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .shared_power_down(shared_power_down), .ramp_counter(ramp_counter), .pwm_pos(pwm_pos), .pwm_neg(pwm_neg));

// ==== digital_comparator_pkg.sv ====
// Constants, register map and carrier types for the three-unit compare PWM block.
// Assumes one 50 MHz clock and a 32-bit Avalon-MM slave port with word-aligned registers.
// What this block does
// [RULE_01] Each unit compares two 8-bit operands.
// [RULE_02] Three independent compare PWM units.
// [RULE_03] Two select lines pick one of four registers.
// [RULE_04] Shared power-down input switches units off.
// [RULE_05] Duty range 0-99.61% or 0.39-100%.
// [RULE_06] Ramp counter sweeps 255 to 0 or up.
// [RULE_07] Compare operand stays steady one ramp period.
// [RULE_08] Positive output high while ramp below compare.
// [RULE_09] After ramp zero, output low until match.
// [RULE_10] Complementary outputs get 10-80 ns dead band; the code gives 40-100 ns.
// [RULE_11] Operand from serial, ADC, counter or register.
// [RULE_12] Four registers hold levels 51,102,154,0.
// [RULE_13] Runs only when power-down released and enabled.
// [RULE_14] High time equals compare counts of 256.
package digital_comparator_pkg;

    localparam int NUM_UNITS     = 3;                   // Independent compare units.
    localparam int NUM_CMP_REGS  = 4;                   // Compare registers per unit.
    localparam int CLK_MHZ       = 50;                  // Clock rate.
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;      // Clock period in ns.
    localparam int DB_STEP_NS    = 10;                  // Dead band step and minimum in ns.

    // Byte addresses of the register map.
    localparam logic [7:0] ADDR_RAMP_CTRL = 8'h00;      // Ramp direction.
    localparam logic [7:0] ADDR_STATUS    = 8'h04;      // Ramp value, outputs, pin level.
    localparam logic [7:0] ADDR_UNIT_BASE = 8'h20;      // First unit block.
    localparam logic [7:0] ADDR_UNIT_SPAN = 8'h20;      // Bytes per unit block.
    localparam logic [7:0] OFS_UNIT_CTRL  = 8'h00;      // Unit control word.
    localparam logic [7:0] OFS_UNIT_CMP0  = 8'h04;      // First compare register.

    // Unit control and status register fields.
    localparam int CTRL_POWER_BIT = 0;
    localparam int CTRL_SRC_LSB   = 1;
    localparam int CTRL_RANGE_BIT = 3;
    localparam int CTRL_DB_LSB    = 4;
    localparam int STAT_POS_LSB   = 8;
    localparam int STAT_NEG_LSB   = 11;
    localparam int STAT_PD_BIT    = 14;

    // Ramp endpoints and reset values.
    localparam logic [7:0] RAMP_TOP      = 8'hff;
    localparam logic [7:0] RAMP_BOTTOM   = 8'h00;
    localparam logic [1:0] CTRL_RESET    = 2'h0;
    localparam logic [7:0] CMP_RESET [NUM_CMP_REGS] = '{8'h33, 8'h66, 8'h9a, 8'h00};

    // Source of the non-ramp operand.
    typedef enum logic [1:0] {
        SRC_REGISTER,
        SRC_ADC,
        SRC_SERIAL,
        SRC_COUNTER
    } operand_src_t;

    // Per-unit configuration as software writes it.
    typedef struct packed {
        logic [2:0]   dead_band;   // Code n asks 10*(n+1) ns; both outputs stay low db_cycles(n)+1 clocks, 40..100 ns.
        logic         full_range;  // 1: 0.39..100 %, 0: 0..99.61 %.
        operand_src_t source;
        logic         power_on;
    } unit_cfg_t;

    // Pair of complementary outputs of one unit.
    typedef struct packed {
        logic pos;
        logic neg;
    } pwm_pair_t;

    // Dead band code to whole clock cycles, rounded up, never below one.
    function automatic logic [2:0] db_cycles(input logic [2:0] code);
        int ns;
        int cyc;
        ns  = DB_STEP_NS * (int'(code) + 1);
        cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (cyc < 1) begin
            cyc = 1;
        end
        return cyc[2:0];
    endfunction : db_cycles

endpackage : digital_comparator_pkg

// ==== digital_compare_pwm_unit.sv ====
// Top of the compare PWM block: Avalon-MM register file, shared ramp counter,
// pin synchronisers and three compare units.
// Assumes select and power-down pins are asynchronous; ADC, serial and counter
// operands come from logic on mclk.
`timescale 1ns/10ps
module digital_compare_pwm_unit
    import digital_comparator_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic [7:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [3:0]           byteenable,
    input  wire logic [31:0]          writedata,
    output logic      [31:0]          readdata,
    output logic                      waitrequest,
    input  wire logic [NUM_UNITS-1:0] register_select_0,
    input  wire logic [NUM_UNITS-1:0] register_select_1,
    input  wire logic                 shared_power_down,
    input  wire logic [7:0]           adc_result,
    input  wire logic [7:0]           serial_buffer,
    input  wire logic [7:0]           counter_value,
    output logic      [7:0]           ramp_counter,
    output logic      [NUM_UNITS-1:0] pwm_pos,
    output logic      [NUM_UNITS-1:0] pwm_neg
);

    // Bus state.
    logic        ack;                 // High in the cycle the access completes.
    logic        next_ack;
    logic [31:0] next_readdata;

    // Configuration state.
    logic        ramp_up;             // 0 counts down from 255, 1 counts up.
    logic        next_ramp_up;
    unit_cfg_t   cfg      [NUM_UNITS];
    unit_cfg_t   next_cfg [NUM_UNITS];
    logic [7:0]  cmp_reg      [NUM_UNITS][NUM_CMP_REGS];
    logic [7:0]  next_cmp_reg [NUM_UNITS][NUM_CMP_REGS];

    // Ramp state.
    logic [7:0]  next_ramp_counter;
    logic        period_start;        // Ramp sits on its first value.

    // Synchronisers: stage one feeds only stage two.
    logic [NUM_UNITS-1:0] sel0_meta;
    logic [NUM_UNITS-1:0] sel0_sync;
    logic [NUM_UNITS-1:0] sel1_meta;
    logic [NUM_UNITS-1:0] sel1_sync;
    logic                 pd_meta;
    logic                 pd_sync;

    // Unit interconnect.
    logic [7:0]  operand  [NUM_UNITS];
    pwm_pair_t   pair     [NUM_UNITS];
    logic        unit_run [NUM_UNITS];

    // Decode helpers.
    logic        in_unit;
    logic [7:0]  unit_ofs;
    logic [1:0]  unit_idx;
    logic [7:0]  rel_addr;
    logic        access;

    // Pins from outside the clock domain pass two flip-flops.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sel0_meta <= '0;
            sel0_sync <= '0;
            sel1_meta <= '0;
            sel1_sync <= '0;
            pd_meta   <= 1'b1;
            pd_sync   <= 1'b1;
        end else begin
            sel0_meta <= register_select_0;
            sel0_sync <= sel0_meta;
            sel1_meta <= register_select_1;
            sel1_sync <= sel1_meta;
            pd_meta   <= shared_power_down;
            pd_sync   <= pd_meta;
        end
    end

    // Address decode into global registers or a unit block.
    always_comb begin
        access   = (read || write) && !ack;
        rel_addr = address - ADDR_UNIT_BASE;
        in_unit  = (address >= ADDR_UNIT_BASE) &&
                   (address < 8'(ADDR_UNIT_BASE + 8'(NUM_UNITS) * ADDR_UNIT_SPAN)) &&
                   (address[1:0] == 2'h0);
        unit_idx = 2'(rel_addr / ADDR_UNIT_SPAN);
        unit_ofs = rel_addr % ADDR_UNIT_SPAN;
    end

    // One wait state on every access; readdata is ready at the completing edge.
    always_comb begin
        waitrequest   = (read || write) && !ack;
        next_ack      = access;
        next_readdata = readdata;
        if (read && access) begin
            next_readdata = 32'h0000_0000;               // Unmapped reads return zero.
            if (address == ADDR_RAMP_CTRL) begin
                next_readdata[0] = ramp_up;
            end else if (address == ADDR_STATUS) begin
                next_readdata[7:0] = ramp_counter;
                next_readdata[STAT_POS_LSB +: NUM_UNITS] = pwm_pos;
                next_readdata[STAT_NEG_LSB +: NUM_UNITS] = pwm_neg;
                next_readdata[STAT_PD_BIT] = pd_sync;
            end else if (in_unit) begin
                if (unit_ofs == OFS_UNIT_CTRL) begin
                    next_readdata[6:0] = cfg[unit_idx];
                end else if (unit_ofs >= OFS_UNIT_CMP0 &&
                             unit_ofs < 8'(OFS_UNIT_CMP0 + 8'(4 * NUM_CMP_REGS))) begin
                    next_readdata[7:0] = cmp_reg[unit_idx][2'((unit_ofs - OFS_UNIT_CMP0) >> 2)];
                end
            end
        end
    end

    // Register writes; only byte lane 0 carries data, wider lanes are ignored.
    always_comb begin
        next_ramp_up = ramp_up;
        next_cfg     = cfg;
        next_cmp_reg = cmp_reg;
        if (write && ack && byteenable[0]) begin
            if (address == ADDR_RAMP_CTRL) begin
                next_ramp_up = writedata[0];             // [RULE_06]
            end else if (in_unit) begin
                if (unit_ofs == OFS_UNIT_CTRL) begin
                    next_cfg[unit_idx] = unit_cfg_t'(writedata[6:0]);
                end else if (unit_ofs >= OFS_UNIT_CMP0 &&
                             unit_ofs < 8'(OFS_UNIT_CMP0 + 8'(4 * NUM_CMP_REGS))) begin
                    next_cmp_reg[unit_idx][2'((unit_ofs - OFS_UNIT_CMP0) >> 2)] = writedata[7:0];
                end
            end
        end
    end

    // Bus and configuration registers.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ack      <= 1'b0;
            readdata <= 32'h0000_0000;
            ramp_up  <= 1'b0;
            for (int u = 0; u < NUM_UNITS; u++) begin
                cfg[u] <= unit_cfg_t'(7'(CTRL_RESET));
                for (int k = 0; k < NUM_CMP_REGS; k++) begin
                    cmp_reg[u][k] <= CMP_RESET[k];       // [RULE_12]
                end
            end
        end else begin
            ack      <= next_ack;
            readdata <= next_readdata;
            ramp_up  <= next_ramp_up;
            cfg      <= next_cfg;
            cmp_reg  <= next_cmp_reg;
        end
    end

    // Free-running ramp through all 256 values in the chosen direction.
    always_comb begin
        if (ramp_up) begin
            next_ramp_counter = ramp_counter + 8'h01;    // [RULE_06]
            period_start      = (ramp_counter == RAMP_BOTTOM);
        end else begin
            next_ramp_counter = ramp_counter - 8'h01;    // [RULE_06]
            period_start      = (ramp_counter == RAMP_TOP);
        end
    end

    // Ramp register.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ramp_counter <= RAMP_TOP;
        end else begin
            ramp_counter <= next_ramp_counter;
        end
    end

    // Operand selection and run gating for each unit.
    // The select pins are decoded live; their two-cycle sync lag is harmless
    // because the unit only samples the operand at period start.
    always_comb begin
        for (int u = 0; u < NUM_UNITS; u++) begin
            case (cfg[u].source)
                SRC_REGISTER: operand[u] = cmp_reg[u][{sel1_sync[u], sel0_sync[u]}]; // [RULE_03] [RULE_12]
                SRC_ADC:      operand[u] = adc_result;    // [RULE_11]
                SRC_SERIAL:   operand[u] = serial_buffer; // [RULE_11]
                SRC_COUNTER:  operand[u] = counter_value; // [RULE_11]
                default:      operand[u] = 8'h00;
            endcase
            // Shared pin must be released and the unit's own power bit set.
            unit_run[u] = !pd_sync && cfg[u].power_on;   // [RULE_04] [RULE_13]
        end
    end

    // Three identical, independent units.
    for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
        pwm_compare_unit u_unit (                        // [RULE_02]
            .mclk         (mclk),
            .sys_rst      (sys_rst),
            .run          (unit_run[g]),
            .cfg          (cfg[g]),
            .ramp         (ramp_counter),
            .period_start (period_start),
            .operand      (operand[g]),
            .outs         (pair[g])
        );
        assign pwm_pos[g] = pair[g].pos;
        assign pwm_neg[g] = pair[g].neg;
    end

endmodule : digital_compare_pwm_unit

// ==== digital_compare_pwm_unit_tb.sv ====
// Self-checking bench for the compare PWM block over its Avalon-MM port.
// Assumes the checker is bound in and the operand model drives the sources.
`timescale 1ns/10ps
module digital_compare_pwm_unit_tb;
    import digital_comparator_pkg::*;
    logic             mclk = 1'b0;
    logic             sys_rst = 1'b1;
    logic [7:0]       address = 8'h00;
    logic             read = 1'b0;
    logic             write = 1'b0;
    logic [31:0]      writedata = 32'h0;
    logic [3:0]       byteenable = 4'hf;
    logic [2:0]       register_select_0 = 3'h0;
    logic [2:0]       register_select_1 = 3'h0;
    logic             shared_power_down = 1'b0;
    logic [7:0]       want [3] = '{8'h40, 8'hc0, 8'h10};
    logic [31:0]      readdata;
    logic             waitrequest;
    logic [7:0]       adc_result, serial_buffer, counter_value, ramp_counter, r;
    logic [2:0]       pwm_pos, pwm_neg;
    logic [31:0]      q;
    int               fail_count = 0;
    int               checked = 0;
    // Compare register reset levels, one per select code.
    localparam logic [7:0] LV [4] = '{8'h33, 8'h66, 8'h9a, 8'h00};

    always #10 mclk = ~mclk;

    digital_compare_pwm_unit u_digital_compare_pwm_unit (.mclk(mclk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .register_select_0(register_select_0), .register_select_1(register_select_1),
        .shared_power_down(shared_power_down), .adc_result(adc_result), .serial_buffer(serial_buffer),
        .counter_value(counter_value), .ramp_counter(ramp_counter), .pwm_pos(pwm_pos), .pwm_neg(pwm_neg));
    operand_source_model u_operand_source_model (.mclk(mclk), .sys_rst(sys_rst), .ramp_counter(ramp_counter),
        .want_adc(want[0]), .want_serial(want[1]), .want_count(want[2]), .adc_result(adc_result),
        .serial_buffer(serial_buffer), .counter_value(counter_value));

    task complete_run;
        if (fail_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One bus cycle, launched just after a rising edge and held until waitrequest is seen low at a rising edge.
    // The design updates only by non-blocking assignment, so values read right after an edge are those it sampled.
    task access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            fail_count++;
            complete_run();
        end
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // One idle edge keeps the strobe from being lowered and raised in one time step.
        @(posedge mclk);
    endtask : access

    task expect_rd(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        check(q, exp);
    endtask : expect_rd

    // Accept a high count from two edges below to one above the db edges lost to the dead band.
    task win(input int seen, input int e, input int db);
        if (e == 0 || e == 256) check(seen, e);
        else check(seen >= e - db - 2 && seen <= e - db + 1, 1);
    endtask : win

    // Let the shadow settle, then count high cycles over one ramp period.
    task duty(input int u, input int e, input int db);
        int p;
        int ng;
        p = 0;
        ng = 0;
        repeat (600) @(posedge mclk);
        repeat (256) begin
            @(negedge mclk);
            p += pwm_pos[u];
            ng += pwm_neg[u];
        end
        win(p, e, db);
        win(ng, 256 - e, db);
        @(posedge mclk);
    endtask : duty

    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 4; i++) expect_rd(8'h24 + 8'(4 * i), {24'h0, LV[i]});
        expect_rd(8'h20, 32'h0);
        access(1'b1, 8'h08, 32'h55);
        expect_rd(8'h08, 32'h0);
        // A write without byte lane 0 must leave the compare register untouched.
        byteenable <= 4'h0;
        access(1'b1, 8'h24, 32'h77);
        byteenable <= 4'hf;
        expect_rd(8'h24, {24'h0, LV[0]});
        access(1'b1, 8'h20, 32'h1);
        for (int i = 0; i < 4; i++) begin
            register_select_0[0] <= i[0];
            register_select_1[0] <= i[1];
            duty(0, int'(LV[i]), 1);
        end
        register_select_0[0] <= 1'b0;
        register_select_1[0] <= 1'b0;
        // Extremes of both duty ranges.
        for (int i = 0; i < 4; i++) begin
            access(1'b1, 8'h24, i[1] ? 32'h0 : 32'hff);
            access(1'b1, 8'h20, {28'h0, i[0], 3'h1});
            duty(0, (i[1] ? 0 : 255) + i[0], 1);
        end
        access(1'b1, 8'h24, 32'h80);
        for (int c = 0; c < 8; c++) begin
            access(1'b1, 8'h20, {25'h0, 3'(c), 4'h1});
            duty(0, 128, c / 2 + 1);
        end
        for (int s = 1; s < 4; s++) begin
            access(1'b1, 8'h40, {29'h0, 2'(s), 1'b1});
            duty(1, int'(want[s-1]), 1);
        end
        access(1'b1, 8'h64, 32'h20);
        access(1'b1, 8'h60, 32'h1);
        duty(2, 32, 1);
        access(1'b1, 8'h40, 32'h0);
        repeat (10) @(posedge mclk);
        check({pwm_pos[1], pwm_neg[1]}, 0);
        shared_power_down <= 1'b1;
        repeat (10) @(posedge mclk);
        check({pwm_pos, pwm_neg}, 0);
        access(1'b0, 8'h04, 32'h0);
        check(q[14], 1);
        shared_power_down <= 1'b0;
        duty(2, 32, 1);
        @(posedge mclk);
        r = ramp_counter;
        @(posedge mclk);
        check(8'(ramp_counter - r), 8'hff);
        access(1'b1, 8'h00, 32'h1);
        @(posedge mclk);
        r = ramp_counter;
        @(posedge mclk);
        check(8'(ramp_counter - r), 8'h01);
        complete_run();
    end
endmodule : digital_compare_pwm_unit_tb

// ==== operand_source_model.sv ====
// Model of the ADC, serial and counter logic that feeds the non-ramp operand.
// Assumes the ramp counts down; new values are loaded mid-ramp only.
`timescale 1ns/10ps
module operand_source_model (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] ramp_counter,
    input  wire logic [7:0] want_adc,
    input  wire logic [7:0] want_serial,
    input  wire logic [7:0] want_count,
    output logic      [7:0] adc_result,
    output logic      [7:0] serial_buffer,
    output logic      [7:0] counter_value
);
    // Loading once per ramp period keeps each value steady over a whole period start.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            adc_result    <= 8'h00;
            serial_buffer <= 8'h00;
            counter_value <= 8'h00;
        end else if (ramp_counter == 8'h80) begin
            adc_result    <= want_adc;
            serial_buffer <= want_serial;
            counter_value <= want_count;
        end
    end
endmodule : operand_source_model

// ==== pwm_compare_unit.sv ====
// One compare PWM unit: operand shadow, comparator and dead band generator.
// Assumes the ramp value and period-start strobe come from the shared ramp counter.
`timescale 1ns/10ps
module pwm_compare_unit
    import digital_comparator_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  unit_cfg_t       cfg,
    input  wire logic [7:0] ramp,
    input  wire logic       period_start,
    input  wire logic [7:0] operand,
    output pwm_pair_t       outs
);

    logic [7:0] shadow;          // Operand held for a whole ramp period.
    logic [7:0] next_shadow;
    logic [2:0] db_count;        // Cycles the raw level has been stable.
    logic [2:0] next_db_count;
    logic       raw_q;           // Raw compare level of the previous cycle.
    logic       next_raw_q;
    pwm_pair_t  next_outs;
    logic       raw;             // Comparator result.

    // Compare: strict less gives 0..255/256, less-or-equal gives 1..256/256.
    always_comb begin
        if (cfg.full_range) begin
            raw = (ramp <= shadow);                      // [RULE_05] [RULE_14]
        end else begin
            raw = (ramp < shadow);                       // [RULE_01] [RULE_08] [RULE_09]
        end
    end

    // Next-state logic for shadow, stability counter and outputs.
    always_comb begin
        next_shadow   = shadow;
        next_db_count = db_count;
        next_raw_q    = raw;
        next_outs     = outs;
        // Sampling only at period start keeps one period's duty consistent.
        if (period_start) begin
            next_shadow = operand;                       // [RULE_07]
        end
        if (!run) begin
            // A powered-down unit drives both outputs low.
            next_outs     = '0;                          // [RULE_04] [RULE_13]
            next_db_count = '0;
        end else if (raw != raw_q) begin
            // Any transition drops both sides first, opening the dead band.
            next_outs     = '0;                          // [RULE_10]
            next_db_count = '0;
        end else if (db_count < db_cycles(cfg.dead_band)) begin
            next_db_count = db_count + 3'h1;
        end else begin
            next_outs.pos = raw;                         // [RULE_10]
            next_outs.neg = !raw;
        end
    end

    // Register stage.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shadow   <= 8'h00;
            db_count <= 3'h0;
            raw_q    <= 1'b0;
            outs     <= '0;
        end else begin
            shadow   <= next_shadow;
            db_count <= next_db_count;
            raw_q    <= next_raw_q;
            outs     <= next_outs;
        end
    end

endmodule : pwm_compare_unit
